// file: hw/adc_scan_sequencer.sv
// Contract
// R1: Each finished conversion packs result and four digital inputs into one FIFO word.
// R2: Result fills upper twelve bits; digital inputs 3..0 fill the low nibble.
// R3: Analog sampled at strobe fall; digital inputs captured at busy rising edge.
// R4: Twelve-bit codes 7FF, 000, FFF, 800 pass through with nibble below.
// R5: Sixteen-bit variant stores the two's-complement code unchanged.
// R6: Unipolar ranges keep two's-complement coding offset by half range.
// R7: One conversion per software start; status flag shows progress and data.
// R8: Queue entry holds channel, gain, polarity and input configuration.
// R9: Conversions follow queue write order; channels may repeat.
// R10: After the last entry, wrap to the first without reload.
// R11: Queue holds up to 512 entries.
// R12: 24-bit scan interval counter times timebase period.
// R13: 16-bit sample interval counter times timebase period.
// R14: 24-bit post-scan counter sets scans after trigger.
// R15: 9-bit samples-per-scan counter sets conversions per scan.
// R16: Scan conversions come from interval counters clocked by selected timebase.
// R17: Software selects internal 40 MHz or external timebase.
// R18: External timebase must be continuous, 1 MHz to 40 MHz; sampled by the 40 MHz clock, it is counted only below 20 MHz.
// R19: Acquisition begins only on detected trigger condition.
// R20: Every finished result goes into the data FIFO.
// R21: Scan interval must be at least sample interval times samples per scan.
// R22: Software loads as many entries as samples per scan.
// R23: Arming resets the queue read pointer to the first entry.
`include "adc_scan_consts.svh"
`default_nettype none
module adc_scan_sequencer #(
  parameter bit PACK_SDI = 1'b1,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Queue loading
  input wire logic q_wr_en,
  input wire logic q_clear,
  input wire logic [`CHAN_W-1:0] q_wr_chan,
  input wire logic [`GAIN_W-1:0] q_wr_gain,
  input wire logic q_wr_unipolar,
  input wire adc_scan_pkg::input_cfg_t q_wr_cfg,
  output logic [`Q_AW:0] q_len,
  // Acquisition control
  input wire logic scan_mode,
  input wire logic arm,
  input wire logic sw_start,
  input wire logic tb_sel_ext,
  input wire logic [`SI_W-1:0] scan_interval_count,
  input wire logic [`SI2_W-1:0] sample_interval_count,
  input wire logic [`PSC_W-1:0] post_scan_count,
  input wire logic [`NCH_W-1:0] samples_per_scan_count,
  output logic conv_active,
  output logic scan_active,
  // Pins
  input wire logic external_reference_clock_in,
  input wire logic trigger_in,
  input wire logic conversion_busy_n,
  input wire logic [`SDI_W-1:0] sync_digital_inputs,
  input wire logic [`WORD_W-1:0] adc_data,
  output logic conv_strobe_n,
  output logic [`CHAN_W-1:0] fe_chan,
  output logic [`GAIN_W-1:0] fe_gain,
  output logic fe_unipolar,
  output adc_scan_pkg::input_cfg_t fe_cfg,
  // Result stream
  output logic data_valid,
  input wire logic data_ready,
  output logic [`WORD_W-1:0] data_out
);
  import adc_scan_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // Every pin passes two flops; edge detect looks only at the second and third
  logic [`PIN_W-1:0] pin_s1_r;
  logic [`PIN_W-1:0] pin_s2_r;
  logic [`PIN_W-1:0] pin_d_r;
  logic ext_rise;
  logic trig_rise;
  logic busy_rise;
  logic tb_tick;
  // Busy idles high; seeding its stages high stops a false done edge after reset
  localparam logic [`PIN_W-1:0] PIN_IDLE = (`PIN_W)'(1'b1) << `PIN_BUSY;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= PIN_IDLE;
      pin_s2_r <= PIN_IDLE;
      pin_d_r <= PIN_IDLE;
    end else begin
      pin_s1_r <= {adc_data, sync_digital_inputs, conversion_busy_n,
                   trigger_in, external_reference_clock_in};
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end
  function automatic logic rise(input logic [`PIN_W-1:0] now,
                                input logic [`PIN_W-1:0] was, input int b);
    rise = now[b] && !was[b];
  endfunction
  assign ext_rise = rise(pin_s2_r, pin_d_r, `PIN_EXT);
  assign trig_rise = rise(pin_s2_r, pin_d_r, `PIN_TRIG); // R19
  assign busy_rise = rise(pin_s2_r, pin_d_r, `PIN_BUSY); // R3
  // External timebase advances counters only on its own edges
  assign tb_tick = tb_sel_ext ? ext_rise : 1'b1; // R17

  ////////////////////////////////////////////////////////////////////////
  // Channel gain queue
  logic [`ENTRY_W-1:0] q_mem [0:`Q_DEPTH-1]; // R11
  logic [`Q_AW:0] q_len_r;
  logic [`Q_AW-1:0] q_rd_r;
  logic [`ENTRY_W-1:0] q_head;
  logic q_full;
  logic go;
  assign q_full = (q_len_r == (`Q_AW+1)'(`Q_DEPTH));
  assign q_len = q_len_r;
  assign q_head = q_mem[q_rd_r];

  always_ff @(posedge ref_clk) begin
    if (q_wr_en && !q_full && !q_clear) begin
      q_mem[q_len_r[`Q_AW-1:0]] <= {q_wr_chan, q_wr_gain, q_wr_unipolar, q_wr_cfg}; // R8
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_len_r <= '0;
    end else if (q_clear) begin
      q_len_r <= '0;
    end else if (q_wr_en && !q_full) begin
      q_len_r <= q_len_r + 1'b1; // R9
    end
  end

  // Read pointer keeps contents and wraps to the first entry
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_rd_r <= '0;
    end else if (q_clear || (arm && scan_mode)) begin
      q_rd_r <= '0; // R23
    end else if (go) begin
      q_rd_r <= ((`Q_AW+1)'(q_rd_r) + 1'b1 >= q_len_r) ? '0 : q_rd_r + 1'b1; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scan timing
  seq_state_t seq_r;
  logic [`SI_W-1:0] si_r;
  logic [`SI2_W-1:0] si2_r;
  logic [`NCH_W-1:0] smp_left_r;
  logic [`PSC_W-1:0] scans_left_r;
  logic scan_req_r;
  logic sw_req_r;
  conv_state_t conv_r;
  logic fifo_in_ready;
  assign scan_active = (seq_r != S_IDLE);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= S_IDLE;
      si_r <= '0;
      si2_r <= '0;
      smp_left_r <= '0;
      scans_left_r <= '0;
    end else begin
      unique case (seq_r)
        S_IDLE: begin
          if (arm && scan_mode) begin
            seq_r <= S_ARMED;
          end
        end
        S_ARMED: begin
          if (trig_rise) begin // R19
            seq_r <= S_RUN;
            si_r <= '0;
            smp_left_r <= '0;
            scans_left_r <= post_scan_count; // R14
          end
        end
        S_RUN: begin
          if (tb_tick) begin // R16
            if (smp_left_r != '0) begin
              si2_r <= (si2_r == '0) ? sample_interval_count - 1'b1
                                     : si2_r - 1'b1; // R13
              if (si2_r == '0) begin
                smp_left_r <= smp_left_r - 1'b1;
              end
            end
            if (si_r != '0) begin
              si_r <= si_r - 1'b1;
            end else if (scans_left_r != '0) begin
              si_r <= scan_interval_count - 1'b1; // R12
              scans_left_r <= scans_left_r - 1'b1;
              smp_left_r <= samples_per_scan_count; // R15
              si2_r <= '0;
            end
          end
          if (scans_left_r == '0 && smp_left_r == '0 && !scan_req_r
              && conv_r == C_IDLE) begin
            seq_r <= S_IDLE;
          end
        end
        default: seq_r <= S_IDLE;
      endcase
    end
  end

  // A sample tick that finds the converter stalled stays pending
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_req_r <= 1'b0;
    end else if (seq_r == S_RUN && tb_tick && smp_left_r != '0 && si2_r == '0) begin
      scan_req_r <= 1'b1; // R16
    end else if (go) begin
      scan_req_r <= 1'b0;
    end
  end

  // Software start, taken only outside scans; a new start beats the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_req_r <= 1'b0;
    end else if (sw_start && !scan_mode && seq_r == S_IDLE) begin
      sw_req_r <= 1'b1; // R7
    end else if (go) begin
      sw_req_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter handshake; no start without room in the FIFO
  logic [3:0] strobe_cnt_r;
  logic cur_uni_r;
  logic push_r;
  logic [`WORD_W-1:0] word_r;
  logic [`WORD_W-1:0] raw;
  assign go = (conv_r == C_IDLE) && fifo_in_ready && !push_r
              && (q_len_r != '0) && (sw_req_r || scan_req_r); // R7
  assign conv_active = (conv_r != C_IDLE) || sw_req_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_r <= C_IDLE;
      conv_strobe_n <= 1'b1;
      strobe_cnt_r <= '0;
      cur_uni_r <= 1'b0;
      fe_chan <= '0;
      fe_gain <= '0;
      fe_unipolar <= 1'b0;
      fe_cfg <= referenced_single_ended;
    end else begin
      unique case (conv_r)
        C_IDLE: begin
          if (go) begin
            {fe_chan, fe_gain, fe_unipolar} <= q_head[`ENTRY_W-1:2]; // R8
            fe_cfg <= input_cfg_t'(q_head[1:0]);
            cur_uni_r <= q_head[2];
            conv_strobe_n <= 1'b0; // R3
            strobe_cnt_r <= 4'(`STROBE_CYC - 1);
            conv_r <= C_STROBE;
          end
        end
        C_STROBE: begin
          if (strobe_cnt_r == '0) begin
            conv_strobe_n <= 1'b1;
            conv_r <= C_WAIT;
          end else begin
            strobe_cnt_r <= strobe_cnt_r - 1'b1;
          end
        end
        C_WAIT: begin
          if (busy_rise) begin
            conv_r <= C_IDLE;
          end
        end
        default: conv_r <= C_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result packing at the end of busy
  assign raw = PACK_SDI
    ? {pin_s2_r[`PIN_DAT_LSB+`RES_MSB -: `WORD_W-`SDI_W],
       pin_s2_r[`PIN_SDI_LSB +: `SDI_W]} // R2
    : pin_s2_r[`PIN_DAT_LSB +: `WORD_W]; // R5

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_r <= '0;
      push_r <= 1'b0;
    end else begin
      push_r <= (conv_r == C_WAIT) && busy_rise; // R20
      if (conv_r == C_WAIT && busy_rise) begin
        // Unipolar converter output is straight binary; flipping the sign bit
        // yields the offset two's-complement code the host expects
        word_r <= {raw[`RES_MSB] ^ cur_uni_r, raw[`RES_MSB-1:0]}; // R1 R4 R6
      end
    end
  end

  adc_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(push_r),
    .in_ready(fifo_in_ready),
    .in_data(word_r),
    .out_valid(data_valid),
    .out_ready(data_ready),
    .out_data(data_out)
  );
endmodule
`default_nettype wire

// file: hw/adc_scan_consts.svh
`ifndef ADC_SCAN_CONSTS_SVH
`define ADC_SCAN_CONSTS_SVH
// Clock rate and conversion strobe low time
`define CLK_MHZ 40
`define STROBE_NS 25
`define STROBE_CYC (((`STROBE_NS) * (`CLK_MHZ) + 999) / 1000)
// Queue and result layout
`define Q_DEPTH 512
`define Q_AW 9
`define CHAN_W 6
`define GAIN_W 2
`define ENTRY_W 11
`define WORD_W 16
`define SDI_W 4
`define RES_MSB 15
`define RES_LSB 4
`define SI_W 24
`define SI2_W 16
`define PSC_W 24
`define NCH_W 9
// Synchronised pin vector layout
`define PIN_W 23
`define PIN_EXT 0
`define PIN_TRIG 1
`define PIN_BUSY 2
`define PIN_SDI_LSB 3
`define PIN_DAT_LSB 7
`endif

// file: hw/adc_scan_pkg.sv
`default_nettype none
package adc_scan_pkg;
  typedef enum logic [1:0] {
    referenced_single_ended,
    nonreferenced_single_ended,
    differential_input
  } input_cfg_t;
  typedef enum logic [1:0] {S_IDLE, S_ARMED, S_RUN} seq_state_t;
  typedef enum logic [1:0] {C_IDLE, C_STROBE, C_WAIT} conv_state_t;
endpackage
`default_nettype wire

// file: hw/adc_fifo.sv
`default_nettype none
module adc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: bench/adc_scan_sequencer_properties.sv
`default_nettype none
module adc_scan_sequencer_properties (
  // Watched top ports
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic q_wr_en,
  input wire logic q_clear,
  input wire logic [9:0] q_len,
  input wire logic scan_mode,
  input wire logic arm,
  input wire logic sw_start,
  input wire logic conv_active,
  input wire logic scan_active,
  input wire logic conv_strobe_n,
  input wire logic data_valid,
  input wire logic data_ready,
  input wire logic [15:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  AST_STROBE_ONE:
    assert property ($fell(conv_strobe_n) |=> conv_strobe_n) else $error("strobe too long");
  AST_SW_TAKEN:
    assert property (sw_start && !scan_mode && !scan_active && !conv_active |=> conv_active)
    else $error("start not taken");
  AST_STROBE_CAUSE:
    assert property (!conv_strobe_n |-> conv_active || scan_active) else $error("stray strobe");
  AST_Q_ADD:
    assert property (q_wr_en && !q_clear && q_len < 10'h200 |=> q_len == $past(q_len) + 10'h1)
    else $error("queue write lost");
  AST_Q_FULL:
    assert property (q_len == 10'h200 && !q_clear |=> q_len == 10'h200) else $error("over full");
  AST_Q_CLEAR:
    assert property (q_clear |=> q_len == 10'h0) else $error("clear failed");
  AST_ARM:
    assert property (arm && scan_mode && !scan_active && !conv_active |=> scan_active)
    else $error("arm ignored");
  AST_HOLD_WORD:
    assert property (data_valid && !data_ready |=> data_valid && $stable(data_out))
    else $error("word dropped");
  cover property ($fell(conv_strobe_n) && !scan_mode);
  cover property ($fell(conv_strobe_n) && scan_mode);
  cover property (data_valid && !data_ready ##1 q_len == 10'h200 || data_valid && !data_ready);
endmodule
bind adc_scan_sequencer adc_scan_sequencer_properties chk_i (.ref_clk, .rst_b, .q_wr_en,
  .q_clear, .q_len, .scan_mode, .arm, .sw_start, .conv_active, .scan_active, .conv_strobe_n,
  .data_valid, .data_ready, .data_out);
`default_nettype wire

// file: bench/adc_front_end_model.sv
`default_nettype none
module adc_front_end_model (
  // Converter pins
  input wire logic conv_strobe_n,
  output logic conversion_busy_n,
  output logic [15:0] adc_data,
  output logic [3:0] sync_digital_inputs,
  // Scenario controls
  input wire logic slow,
  input wire logic [15:0] code,
  input wire logic [3:0] sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    conversion_busy_n = 1'b1;
    adc_data = 16'h0;
    sync_digital_inputs = 4'h0;
  end
  always @(negedge conv_strobe_n) begin
    #10 conversion_busy_n = 1'b0;
    #(slow ? 2000 : 300);
    adc_data = code;
    sync_digital_inputs = sdi;
    conversion_busy_n = 1'b1;
    // After the hold time the lines carry garbage, never the old word
    #100 adc_data = ~code;
    sync_digital_inputs = ~sdi;
  end
endmodule
`default_nettype wire

// file: bench/adc_scan_sequencer_test.sv
`default_nettype none
module adc_scan_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_scan_pkg::*;
  typedef struct {logic [5:0] ch; logic [1:0] g; logic u; input_cfg_t c;} ent_t;
  typedef struct {logic [15:0] code; logic [3:0] sdi;} row_t;
  logic ref_clk = 1'b0, rst_b = 1'b0, q_wr_en = 1'b0, q_clear = 1'b0, q_wr_unipolar = 1'b0;
  logic scan_mode = 1'b0, arm = 1'b0, sw_start = 1'b0, tb_sel_ext = 1'b0, ext_clk = 1'b0;
  logic trigger_in = 1'b0, data_ready = 1'b0, slow = 1'b0;
  logic [5:0] q_wr_chan = 6'h0, fe_chan;
  logic [1:0] q_wr_gain = 2'h0, fe_gain;
  input_cfg_t q_wr_cfg = referenced_single_ended, fe_cfg;
  logic [23:0] scan_interval_count = 24'h0, post_scan_count = 24'h0, cyc = 24'h0;
  logic [15:0] sample_interval_count = 16'h0, code = 16'h0, adc_data, data_out;
  logic [8:0] samples_per_scan_count = 9'h0;
  logic [3:0] sdi = 4'h0, sync_digital_inputs;
  logic [9:0] q_len;
  logic conv_active, scan_active, conversion_busy_n, conv_strobe_n, fe_unipolar, data_valid;
  logic strobe, idle, scan_idle;
  logic [23:0] st_t[$];
  logic [5:0] st_ch[$];
  logic [15:0] expq[$];
  int n_errors = 0, comparisons = 0, idx = 0;
  ent_t ents[4] = '{'{6'h03, 2'h0, 1'b0, referenced_single_ended},
    '{6'h01, 2'h2, 1'b0, differential_input}, '{6'h02, 2'h1, 1'b1, nonreferenced_single_ended},
    '{6'h01, 2'h2, 1'b0, differential_input}};
  row_t rows[6] = '{'{16'h7ff3, 4'ha}, '{16'h0000, 4'h5}, '{16'h0000, 4'hf},
    '{16'hfff0, 4'h0}, '{16'h8000, 4'h3}, '{16'h1234, 4'h9}};
  assign strobe = !conv_strobe_n;
  assign idle = !conv_active;
  assign scan_idle = !scan_active;
  always #12.5 ref_clk = ~ref_clk;
  always #100 if (tb_sel_ext) ext_clk = ~ext_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 24'h1;
    if (strobe) begin
      st_t.push_back(cyc);
      st_ch.push_back(fe_chan);
    end
  end
  adc_scan_sequencer dut (.ref_clk, .rst_b, .q_wr_en, .q_clear, .q_wr_chan, .q_wr_gain,
    .q_wr_unipolar, .q_wr_cfg, .q_len, .scan_mode, .arm, .sw_start, .tb_sel_ext,
    .scan_interval_count, .sample_interval_count, .post_scan_count, .samples_per_scan_count,
    .conv_active, .scan_active, .external_reference_clock_in(ext_clk), .trigger_in,
    .conversion_busy_n, .sync_digital_inputs, .adc_data, .conv_strobe_n, .fe_chan, .fe_gain,
    .fe_unipolar, .fe_cfg, .data_valid, .data_ready, .data_out);
  adc_front_end_model fe (.conv_strobe_n, .conversion_busy_n, .adc_data, .sync_digital_inputs,
    .slow, .code, .sdi);
  ////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    for (int i = 0; i < lim && s !== 1'b1; i++) @(negedge ref_clk);
    if (s !== 1'b1) begin
      n_errors++;
      $display("BAD wait expected 1 seen %b", s);
      stop_test();
    end
  endtask
  // Unipolar codes arrive straight binary, so the sign bit flips
  function automatic logic [15:0] word(row_t r, ent_t e);
    return {r.code[15] ^ e.u, r.code[14:4], r.sdi};
  endfunction
  task automatic conv(row_t r, bit held);
    ent_t e;
    int n;
    e = ents[idx % 4];
    n = st_t.size();
    code = r.code;
    sdi = r.sdi;
    sw_start = 1'b1;
    @(negedge ref_clk);
    sw_start = 1'b0;
    expq.push_back(word(r, e));
    idx++;
    if (held) begin
      repeat (30) @(negedge ref_clk);
      chk("held", n[23:0], st_t.size());
    end else begin
      wait_hi(strobe, 20);
      chk("entry", {e.ch, e.g, e.u, e.c}, {fe_chan, fe_gain, fe_unipolar, fe_cfg});
      wait_hi(idle, 200);
    end
  endtask
  task automatic pop;
    wait_hi(data_valid, 200);
    chk("word", expq.pop_front(), data_out);
    data_ready = 1'b1;
    @(negedge ref_clk);
    data_ready = 1'b0;
    // Let an edge pass so back-to-back pops never re-raise ready in one step
    @(negedge ref_clk);
  endtask
  task automatic run_scan(int n);
    st_t.delete();
    st_ch.delete();
    arm = 1'b1;
    @(negedge ref_clk);
    arm = 1'b0;
    repeat (50) @(negedge ref_clk);
    chk("armed", 24'd0, st_t.size());
    trigger_in = 1'b1;
    wait_hi(scan_idle, 3000);
    trigger_in = 1'b0;
    chk("count", n[23:0], st_t.size());
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("reset", 24'h2000, {conv_strobe_n, data_valid, conv_active, scan_active, q_len});
    $display("Test reset done");
    q_wr_en = 1'b1;
    repeat (513) @(negedge ref_clk);
    q_wr_en = 1'b0;
    chk("full", 24'h200, q_len);
    q_clear = 1'b1;
    @(negedge ref_clk);
    q_clear = 1'b0;
    q_wr_en = 1'b1;
    foreach (ents[i]) begin
      q_wr_chan = ents[i].ch;
      q_wr_gain = ents[i].g;
      q_wr_unipolar = ents[i].u;
      q_wr_cfg = ents[i].c;
      @(negedge ref_clk);
    end
    q_wr_en = 1'b0;
    chk("q_len", 24'h4, q_len);
    $display("Test queue done");
    foreach (rows[i]) begin
      slow = i[0];
      conv(rows[i], 1'b0);
      pop();
    end
    $display("Test polling done");
    for (int i = 0; i < 8; i++) conv(rows[i % 6], 1'b0);
    conv(rows[1], 1'b1);
    repeat (9) pop();
    $display("Test fifo done");
    scan_mode = 1'b1;
    data_ready = 1'b1;
    // Slow conversions would outlast the sample interval and skew the gaps
    slow = 1'b0;
    samples_per_scan_count = 9'h4;
    post_scan_count = 24'h3;
    sample_interval_count = 16'h28;
    scan_interval_count = 24'hc8;
    run_scan(12);
    for (int j = 0; j < 12; j++) begin
      chk("chan", ents[j % 4].ch, st_ch[j]);
      if (j % 4) chk("gap", 24'd40, st_t[j] - st_t[j - 1]);
      else if (j > 0) chk("scan", 24'd200, st_t[j] - st_t[j - 4]);
    end
    tb_sel_ext = 1'b1;
    samples_per_scan_count = 9'h2;
    post_scan_count = 24'h1;
    sample_interval_count = 16'h4;
    scan_interval_count = 24'h8;
    run_scan(2);
    chk("ext gap", 24'd32, st_t[1] - st_t[0]);
    $display("Test scan done");
    rst_b = 1'b0;
    @(negedge ref_clk);
    chk("mid reset", 24'h2000, {conv_strobe_n, data_valid, conv_active, scan_active, q_len});
    rst_b = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("after reset", 24'h2000, {conv_strobe_n, data_valid, conv_active, scan_active, q_len});
    $display("Test mid reset done");
    stop_test();
  end
endmodule
`default_nettype wire
